// *** inc/omtc_pkg.sv ***
/*
  Package for the operating-mode transition controller.
  Holds the mode encoding, reset values and settling-time constants.
  Assumes a single 40 MHz core clock and synchronous active-high reset.
*/
package omtc_pkg;

  // Operating modes, one-hot.
  typedef enum logic [8:0] {
    OMTC_RESET     = 9'h001,
    OMTC_ACT_HIGH  = 9'h002,
    OMTC_ACT_MED   = 9'h004,
    OMTC_SUBACT    = 9'h008,
    OMTC_SLP_HIGH  = 9'h010,
    OMTC_SLP_MED   = 9'h020,
    OMTC_SUBSLEEP  = 9'h040,
    OMTC_STANDBY   = 9'h080,
    OMTC_WATCH     = 9'h100
  } omtc_mode_e;

  localparam int unsigned OMTC_SETTLE_W = 3;
  localparam int unsigned OMTC_CNT_W = 16;
  // Settling time in clock cycles for code 0 of the settling field; each code step doubles it.
  localparam logic [OMTC_CNT_W-1:0] OMTC_SETTLE_BASE = 16'h0008;
  localparam logic [1:0] OMTC_SUBDIV_RST = 2'h0;
  localparam logic [OMTC_CNT_W-1:0] OMTC_CNT_RST = 16'h0000;

endpackage

// *** hdl/omtc_ctrl.sv ***
/*
  Operating-mode transition controller: chooses the halt or run mode on a
  sleep request, wakes on interrupts, and handles reset.
  Assumes the processor core drives sleep_req_i and the interrupt inputs on
  core_clk_i; only the external reset pin is asynchronous and synchronised.
*/
`timescale 1ns/10ps

// Function
// [R1] A sleep request moves a running mode to the halted mode chosen by the select bits.
// [R2] An interrupt in any halted mode returns to a running mode.
// [R3] From active with no direct transition, standby and watch bits pick sleep, standby or watch.
// [R4] Wake targets: sleep to same-speed active, subsleep to subactive, others by the speed bits.
// [R5] From subactive, low-speed 1, standby 0, watch 1, direct 0 enters subsleep.
// [R6] Direct transition to active high-speed needs standby 0 from active, standby and watch 1 from subactive.
// [R7] Direct transition to active medium-speed uses the same conditions with the medium bit set.
// [R8] Low-speed, standby, watch and direct all 1 go to subactive; from medium active the medium bit too.
// [R9] Direct transitions never pass through a halted mode.
// [R10] Active to active and subactive to subactive direct transitions are allowed.
// [R11] The external reset pin forces the reset state from any mode.
// [R12] The system oscillator runs only in active and sleep; instructions run only in active and subactive.
// The code also runs the oscillator in the reset state and while standby settles.
// [R13] A maskable interrupt does not wake when the global mask is set or its enable is clear.
// [R14] Leaving standby restarts the system clock and waits the selected settling time first.
// [R15] The subclock divide is 8, 4, 2 or 1 for codes 00 to 11, taking effect after the sleep request.
// [R16] Select combinations matching no row leave the running mode unchanged.
// [R17] The non-maskable interrupt wakes every halted mode.
module omtc_ctrl (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic external_reset_n_i,
  input wire logic sleep_req_i,
  input wire logic irq_req_i,
  input wire logic irq_enable_i,
  input wire logic global_irq_mask_i,
  input wire logic nmi_req_i,
  input wire logic low_speed_select_i,
  input wire logic medium_speed_select_i,
  input wire logic software_standby_select_i,
  input wire logic watch_mode_select_i,
  input wire logic direct_transition_select_i,
  input wire logic [2:0] standby_settle_time_field_i,
  input wire logic [1:0] sub_clk_div_sel_i,
  output logic [8:0] mode_o,
  output logic sys_osc_en_o,
  output logic cpu_run_o,
  output logic irq_handle_o,
  output logic [1:0] sub_clk_div_sel_o,
  output logic [3:0] sub_clk_div_o
);

  omtc_pkg::omtc_mode_e mode_q, mode_d;
  logic rst_meta_q, rst_sync_q;
  logic settling_q;
  logic [omtc_pkg::OMTC_CNT_W-1:0] settle_cnt_q;
  logic [1:0] subdiv_q;
  logic wake;
  omtc_pkg::omtc_mode_e wake_mode;

  // Settling time grows by powers of two with the field code.
  function automatic logic [omtc_pkg::OMTC_CNT_W-1:0] settle_cycles(input logic [2:0] code);
    settle_cycles = omtc_pkg::OMTC_SETTLE_BASE << code;
  endfunction

  // Mode reached on wake from a halted mode that wakes to active or subactive.
  function automatic omtc_pkg::omtc_mode_e speed_mode(input logic ls, input logic ms);
    if (ls) begin
      speed_mode = omtc_pkg::OMTC_SUBACT;
    end else if (ms) begin
      speed_mode = omtc_pkg::OMTC_ACT_MED;
    end else begin
      speed_mode = omtc_pkg::OMTC_ACT_HIGH;
    end
  endfunction

  // Two-flop synchroniser for the reset pin, which is asynchronous to the core clock.
  // Cleared by the core reset so that release reaches active mode on the first edge.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= ~external_reset_n_i;
      rst_sync_q <= rst_meta_q;
    end
  end

  // Masked interrupts are ignored; the non-maskable one always wakes.
  assign wake = nmi_req_i | (irq_req_i & irq_enable_i & ~global_irq_mask_i); // [R13] [R17]

  // Wake target depends on the halted mode.
  always_comb begin
    wake_mode = omtc_pkg::OMTC_ACT_HIGH;
    unique case (mode_q)
      omtc_pkg::OMTC_SLP_HIGH: wake_mode = omtc_pkg::OMTC_ACT_HIGH; // [R4]
      omtc_pkg::OMTC_SLP_MED: wake_mode = omtc_pkg::OMTC_ACT_MED; // [R4]
      omtc_pkg::OMTC_SUBSLEEP: wake_mode = omtc_pkg::OMTC_SUBACT; // [R4]
      omtc_pkg::OMTC_STANDBY: wake_mode = speed_mode(1'b0, medium_speed_select_i); // [R4]
      omtc_pkg::OMTC_WATCH: wake_mode = speed_mode(low_speed_select_i, medium_speed_select_i); // [R4]
      default: wake_mode = mode_q;
    endcase
  end

  // Next-mode decode for a sleep request; unmatched rows keep the current mode.
  always_comb begin
    logic ls, ms, sb, wt, dt;
    ls = low_speed_select_i;
    ms = medium_speed_select_i;
    sb = software_standby_select_i;
    wt = watch_mode_select_i;
    dt = direct_transition_select_i;
    mode_d = mode_q; // [R16]
    unique case (mode_q)
      omtc_pkg::OMTC_RESET: mode_d = omtc_pkg::OMTC_ACT_HIGH;
      omtc_pkg::OMTC_ACT_HIGH, omtc_pkg::OMTC_ACT_MED: begin
        if (sleep_req_i) begin
          if (!ls && !sb) begin
            if (!dt) begin
              mode_d = ms ? omtc_pkg::OMTC_SLP_MED : omtc_pkg::OMTC_SLP_HIGH; // [R1] [R3]
            end else begin
              mode_d = ms ? omtc_pkg::OMTC_ACT_MED : omtc_pkg::OMTC_ACT_HIGH; // [R6] [R7] [R10]
            end
          end else if (sb && !wt && !ls && !dt) begin
            mode_d = omtc_pkg::OMTC_STANDBY; // [R3]
          end else if (sb && wt && !dt && (!ls || mode_q == omtc_pkg::OMTC_ACT_HIGH || ms)) begin
            mode_d = omtc_pkg::OMTC_WATCH; // [R3]
          end else if (ls && sb && wt && dt && (mode_q == omtc_pkg::OMTC_ACT_HIGH || ms)) begin
            mode_d = omtc_pkg::OMTC_SUBACT; // [R8] [R9]
          end
        end
      end
      omtc_pkg::OMTC_SUBACT: begin
        if (sleep_req_i) begin
          if (ls && !sb && wt && !dt) begin
            mode_d = omtc_pkg::OMTC_SUBSLEEP; // [R5]
          end else if (sb && wt && !dt) begin
            mode_d = omtc_pkg::OMTC_WATCH; // [R1]
          end else if (sb && wt && dt) begin
            mode_d = speed_mode(ls, ms); // [R6] [R7] [R8] [R9] [R10]
          end
        end
      end
      omtc_pkg::OMTC_SLP_HIGH, omtc_pkg::OMTC_SLP_MED, omtc_pkg::OMTC_SUBSLEEP,
      omtc_pkg::OMTC_WATCH: begin
        if (wake && !(mode_q == omtc_pkg::OMTC_WATCH && wake_mode != omtc_pkg::OMTC_SUBACT)) begin
          mode_d = wake_mode; // [R2]
        end else if (wake) begin
          mode_d = omtc_pkg::OMTC_STANDBY; // Watch to active reuses the settling path.
        end
      end
      omtc_pkg::OMTC_STANDBY: begin
        if (settling_q && settle_cnt_q == omtc_pkg::OMTC_CNT_RST) begin
          mode_d = wake_mode; // [R14]
        end
      end
      default: mode_d = omtc_pkg::OMTC_RESET;
    endcase
  end

  // Mode register; the synchronised reset pin wins over everything.
  always_ff @(posedge core_clk_i) begin
    if (srst_i || rst_sync_q) begin
      mode_q <= omtc_pkg::OMTC_RESET; // [R11]
    end else begin
      mode_q <= mode_d;
    end
  end

  // Settling counter: starts on wake in standby, or on watch-to-active wake.
  // Reusing the standby state for the watch wake keeps one counter for both.
  always_ff @(posedge core_clk_i) begin
    if (srst_i || rst_sync_q) begin
      settling_q <= 1'b0;
      settle_cnt_q <= omtc_pkg::OMTC_CNT_RST;
    end else if (mode_q == omtc_pkg::OMTC_WATCH && mode_d == omtc_pkg::OMTC_STANDBY) begin
      settling_q <= 1'b1;
      settle_cnt_q <= settle_cycles(standby_settle_time_field_i) - 16'h0001; // [R14]
    end else if (mode_q == omtc_pkg::OMTC_STANDBY && !settling_q && wake) begin
      settling_q <= 1'b1;
      settle_cnt_q <= settle_cycles(standby_settle_time_field_i) - 16'h0001; // [R14]
    end else if (settling_q && settle_cnt_q != omtc_pkg::OMTC_CNT_RST) begin
      settle_cnt_q <= settle_cnt_q - 16'h0001;
    end else begin
      settling_q <= 1'b0;
    end
  end

  // Subclock divide select is latched when a sleep request is accepted.
  always_ff @(posedge core_clk_i) begin
    if (srst_i || rst_sync_q) begin
      subdiv_q <= omtc_pkg::OMTC_SUBDIV_RST;
    end else if (sleep_req_i && cpu_run_o) begin
      subdiv_q <= sub_clk_div_sel_i; // [R15]
    end
  end

  // Outputs derived from the current and next mode, the settling flag and the latched divide code.
  assign mode_o = mode_q;
  assign sys_osc_en_o = (mode_q == omtc_pkg::OMTC_ACT_HIGH) || (mode_q == omtc_pkg::OMTC_ACT_MED)
    || (mode_q == omtc_pkg::OMTC_SLP_HIGH) || (mode_q == omtc_pkg::OMTC_SLP_MED)
    || (mode_q == omtc_pkg::OMTC_RESET) || settling_q; // [R12] [R14]
  assign cpu_run_o = (mode_q == omtc_pkg::OMTC_ACT_HIGH) || (mode_q == omtc_pkg::OMTC_ACT_MED)
    || (mode_q == omtc_pkg::OMTC_SUBACT); // [R12]
  assign irq_handle_o = (mode_q != mode_d) && !cpu_run_o && (mode_d != omtc_pkg::OMTC_STANDBY)
    && (mode_d != omtc_pkg::OMTC_RESET);
  assign sub_clk_div_sel_o = subdiv_q;
  assign sub_clk_div_o = 4'h8 >> subdiv_q; // [R15]

  // A wake from medium-speed sleep lands in active medium-speed on the next edge.
  a_sleep_wake: assert property (@(posedge core_clk_i) disable iff (srst_i || rst_sync_q)
    mode_q == omtc_pkg::OMTC_SLP_MED && wake |=> mode_q == omtc_pkg::OMTC_ACT_MED) // [R4]
    else $error("sleep medium did not wake to active medium");

  // Subsleep entry from subactive.
  a_subsleep_entry: assert property (@(posedge core_clk_i) disable iff (srst_i || rst_sync_q)
    mode_q == omtc_pkg::OMTC_SUBACT && sleep_req_i && low_speed_select_i
    && !software_standby_select_i && watch_mode_select_i && !direct_transition_select_i
    |=> mode_q == omtc_pkg::OMTC_SUBSLEEP) // [R5]
    else $error("subsleep not entered");

  // Globally masked interrupts never leave high-speed sleep.
  a_masked_stay: assert property (@(posedge core_clk_i) disable iff (srst_i || rst_sync_q)
    mode_q == omtc_pkg::OMTC_SLP_HIGH && !nmi_req_i && global_irq_mask_i
    |=> mode_q == omtc_pkg::OMTC_SLP_HIGH) // [R13]
    else $error("masked interrupt woke sleep");

  // Non-maskable interrupt wakes subsleep.
  a_nmi_wake: assert property (@(posedge core_clk_i) disable iff (srst_i || rst_sync_q)
    mode_q == omtc_pkg::OMTC_SUBSLEEP && nmi_req_i |=> mode_q == omtc_pkg::OMTC_SUBACT) // [R17]
    else $error("nmi did not wake subsleep");

  // Oscillator is off in subactive.
  a_osc_off: assert property (@(posedge core_clk_i) disable iff (srst_i)
    mode_q == omtc_pkg::OMTC_SUBACT |-> !sys_osc_en_o && cpu_run_o) // [R12]
    else $error("oscillator running in subactive");

  // Reset pin reaches the reset state within three edges.
  a_pin_reset: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !external_reset_n_i |-> ##[1:3] mode_q == omtc_pkg::OMTC_RESET) // [R11]
    else $error("reset pin ignored");

  // Direct transitions never halt the processor.
  a_direct_run: assert property (@(posedge core_clk_i) disable iff (srst_i || rst_sync_q)
    cpu_run_o && sleep_req_i && direct_transition_select_i |=> cpu_run_o) // [R9]
    else $error("direct transition halted the cpu");

  // Standby wake waits the settling time before leaving.
  sequence s_standby_wake;
    mode_q == omtc_pkg::OMTC_STANDBY && !settling_q && wake;
  endsequence
  a_standby_settle: assert property (@(posedge core_clk_i) disable iff (srst_i || rst_sync_q)
    s_standby_wake |=> (mode_q == omtc_pkg::OMTC_STANDBY && sys_osc_en_o)[*7]) // [R14]
    else $error("standby left before settling");

  // Sleep request from active with standby 0 and direct 0 enters sleep.
  a_sleep_entry: assert property (@(posedge core_clk_i) disable iff (srst_i || rst_sync_q)
    mode_q == omtc_pkg::OMTC_ACT_HIGH && sleep_req_i && !low_speed_select_i
    && !software_standby_select_i && !direct_transition_select_i && !medium_speed_select_i
    |=> mode_q == omtc_pkg::OMTC_SLP_HIGH) // [R1] [R3]
    else $error("sleep not entered");

  // Standby bit with watch clear enters standby from active.
  a_standby_entry: assert property (@(posedge core_clk_i) disable iff (srst_i || rst_sync_q)
    mode_q == omtc_pkg::OMTC_ACT_HIGH && sleep_req_i && !low_speed_select_i
    && software_standby_select_i && !watch_mode_select_i && !direct_transition_select_i
    |=> mode_q == omtc_pkg::OMTC_STANDBY) // [R3]
    else $error("standby not entered");

  // Standby and watch bits together enter watch from active.
  a_watch_entry: assert property (@(posedge core_clk_i) disable iff (srst_i || rst_sync_q)
    mode_q == omtc_pkg::OMTC_ACT_HIGH && sleep_req_i && !low_speed_select_i
    && software_standby_select_i && watch_mode_select_i && !direct_transition_select_i
    |=> mode_q == omtc_pkg::OMTC_WATCH) // [R3]
    else $error("watch not entered");

  // Direct transition from medium active to high-speed active.
  a_direct_high: assert property (@(posedge core_clk_i) disable iff (srst_i || rst_sync_q)
    mode_q == omtc_pkg::OMTC_ACT_MED && sleep_req_i && !low_speed_select_i
    && !medium_speed_select_i && !software_standby_select_i && direct_transition_select_i
    |=> mode_q == omtc_pkg::OMTC_ACT_HIGH) // [R6]
    else $error("direct high-speed transition missed");

  // Direct transition from subactive to medium active.
  a_direct_med: assert property (@(posedge core_clk_i) disable iff (srst_i || rst_sync_q)
    mode_q == omtc_pkg::OMTC_SUBACT && sleep_req_i && !low_speed_select_i && medium_speed_select_i
    && software_standby_select_i && watch_mode_select_i && direct_transition_select_i
    |=> mode_q == omtc_pkg::OMTC_ACT_MED) // [R7]
    else $error("direct medium-speed transition missed");

  // Direct transition from high-speed active to subactive.
  a_direct_sub: assert property (@(posedge core_clk_i) disable iff (srst_i || rst_sync_q)
    mode_q == omtc_pkg::OMTC_ACT_HIGH && sleep_req_i && low_speed_select_i
    && software_standby_select_i && watch_mode_select_i && direct_transition_select_i
    |=> mode_q == omtc_pkg::OMTC_SUBACT) // [R8]
    else $error("direct subactive transition missed");

  // A low-speed request with standby clear matches no row from active and is ignored.
  a_reject_unlisted: assert property (@(posedge core_clk_i) disable iff (srst_i || rst_sync_q)
    mode_q == omtc_pkg::OMTC_ACT_HIGH && sleep_req_i && low_speed_select_i
    && !software_standby_select_i |=> mode_q == omtc_pkg::OMTC_ACT_HIGH) // [R16]
    else $error("unlisted select combination changed the mode");

  // Any wake from subsleep returns to subactive.
  a_subsleep_wake: assert property (@(posedge core_clk_i) disable iff (srst_i || rst_sync_q)
    mode_q == omtc_pkg::OMTC_SUBSLEEP && wake |=> mode_q == omtc_pkg::OMTC_SUBACT) // [R2] [R4]
    else $error("subsleep did not wake to subactive");

  // Watch mode halts both the oscillator and the processor.
  a_watch_halt: assert property (@(posedge core_clk_i) disable iff (srst_i || rst_sync_q)
    mode_q == omtc_pkg::OMTC_WATCH |-> !sys_osc_en_o && !cpu_run_o) // [R12]
    else $error("watch mode left a clock or the cpu running");

  // The divide code is taken with an accepted sleep request.
  a_div_latch: assert property (@(posedge core_clk_i) disable iff (srst_i || rst_sync_q)
    sleep_req_i && cpu_run_o |=> sub_clk_div_sel_o == $past(sub_clk_div_sel_i)) // [R15]
    else $error("subclock divide code not latched");

endmodule

// *** dv/omtc_core_model.sv ***
/*
  Behavioural processor core that issues sleep pulses and wake requests.
  Assumes the bench calls its tasks from the falling clock edge.
*/
`timescale 1ns/10ps

module omtc_core_model (
  input wire logic core_clk_i,
  output logic sleep_req_o,
  output logic irq_req_o,
  output logic irq_enable_o,
  output logic global_irq_mask_o,
  output logic nmi_req_o
);
  // An idle core requests nothing and leaves interrupts enabled and unmasked.
  initial begin
    sleep_req_o = 1'b0;
    quiet();
  end

  // One-cycle sleep pulse, moved on the falling edge so the rising edge sees it settled.
  task automatic sleep_pulse();
    @(negedge core_clk_i);
    sleep_req_o = 1'b1;
    @(negedge core_clk_i);
    sleep_req_o = 1'b0;
  endtask

  // A delay lets the core answer promptly or slowly; blk 1 masks, blk 2 disables.
  task automatic request(input int unsigned dly, input logic use_nmi, input logic [1:0] blk);
    repeat (dly) @(negedge core_clk_i);
    global_irq_mask_o = (blk == 2'h1);
    irq_enable_o = (blk != 2'h2);
    irq_req_o = !use_nmi;
    nmi_req_o = use_nmi;
  endtask

  // Withdraw every request once the device runs again.
  task automatic quiet();
    irq_req_o = 1'b0;
    nmi_req_o = 1'b0;
    global_irq_mask_o = 1'b0;
    irq_enable_o = 1'b1;
  endtask
endmodule

// *** dv/testbench.sv ***
/*
  Self-checking bench for the operating-mode controller with random select bits.
  Assumes the core model drives the request lines on the falling edge.
*/
`timescale 1ns/10ps

module testbench;
  logic core_clk_i, srst_i, rst_n, slp, irq, irq_en, irq_msk, nmi, osc, run, hdl;
  logic [4:0] sel;
  logic [2:0] settle;
  logic [1:0] dsel, dsel_q;
  logic [8:0] mode;
  logic [3:0] div;
  logic [4:0] corner [5] = '{5'h09, 5'h17, 5'h1F, 5'h12, 5'h07};
  int bad_count = 0;
  int tests_run = 0;

  omtc_ctrl omtc_ctrl_inst (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .external_reset_n_i(rst_n),
    .sleep_req_i(slp), .irq_req_i(irq), .irq_enable_i(irq_en),
    .global_irq_mask_i(irq_msk), .nmi_req_i(nmi), .low_speed_select_i(sel[4]),
    .medium_speed_select_i(sel[3]), .software_standby_select_i(sel[2]),
    .watch_mode_select_i(sel[1]), .direct_transition_select_i(sel[0]),
    .standby_settle_time_field_i(settle), .sub_clk_div_sel_i(dsel), .mode_o(mode),
    .sys_osc_en_o(osc), .cpu_run_o(run), .irq_handle_o(hdl),
    .sub_clk_div_sel_o(dsel_q), .sub_clk_div_o(div)
  );

  omtc_core_model omtc_core_model_inst (
    .core_clk_i(core_clk_i), .sleep_req_o(slp), .irq_req_o(irq),
    .irq_enable_o(irq_en), .global_irq_mask_o(irq_msk), .nmi_req_o(nmi)
  );

  // Mode after a sleep request; s is {low, medium, standby, watch, direct}.
  function automatic logic [8:0] exp_sleep(input logic [8:0] cur, input logic [4:0] s);
    logic act, ok;
    act = (cur != omtc_pkg::OMTC_SUBACT);
    ok = !act || s[3] || cur == omtc_pkg::OMTC_ACT_HIGH;
    exp_sleep = cur;
    casez ({act, s})
      6'b10?0?0: exp_sleep = s[3] ? omtc_pkg::OMTC_SLP_MED : omtc_pkg::OMTC_SLP_HIGH;
      6'b10?100: exp_sleep = omtc_pkg::OMTC_STANDBY;
      6'b?0?110: exp_sleep = omtc_pkg::OMTC_WATCH;
      6'b?1?11?: if (ok) exp_sleep = s[0] ? omtc_pkg::OMTC_SUBACT : omtc_pkg::OMTC_WATCH;
      6'b10?0?1, 6'b00?111: exp_sleep = s[3] ? omtc_pkg::OMTC_ACT_MED : omtc_pkg::OMTC_ACT_HIGH;
      6'b01?010: exp_sleep = omtc_pkg::OMTC_SUBSLEEP;
      default: exp_sleep = cur;
    endcase
  endfunction

  // Running mode reached when a halted mode wakes.
  function automatic logic [8:0] exp_wake(input logic [8:0] m, input logic [4:0] s);
    exp_wake = omtc_pkg::OMTC_ACT_HIGH;
    if (m == omtc_pkg::OMTC_SLP_MED || (m != omtc_pkg::OMTC_SLP_HIGH && s[3]))
      exp_wake = omtc_pkg::OMTC_ACT_MED;
    if (m == omtc_pkg::OMTC_SUBSLEEP || (m == omtc_pkg::OMTC_WATCH && s[4]))
      exp_wake = omtc_pkg::OMTC_SUBACT;
  endfunction

  // Compare and count; four-state equality so an unknown never matches.
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  // Forty passes with the longest settle stay far below this ceiling.
  initial begin
    repeat (90000) @(posedge core_clk_i);
    bad_count++;
    close_out();
  end

  // Random sleep and wake passes, the first five hand-picked as corner cases.
  initial begin
    logic [8:0] cur, nxt;
    logic seen;
    int n;
    srst_i = 1'b1;
    rst_n = 1'b1;
    sel = 5'h00;
    settle = 3'h0;
    dsel = 2'h0;
    n = $urandom(51);
    repeat (10) @(negedge core_clk_i);
    srst_i = 1'b0;
    @(negedge core_clk_i);
    cur = omtc_pkg::OMTC_ACT_HIGH;
    check("mode after reset", cur, mode);
    for (int i = 0; i < 40; i++) begin
      sel = (i < 5) ? corner[i] : 5'($urandom);
      settle = 3'($urandom);
      dsel = 2'($urandom);
      nxt = exp_sleep(cur, sel);
      omtc_core_model_inst.sleep_pulse();
      check("mode after sleep", nxt, mode);
      check("cpu run", nxt inside {9'h002, 9'h004, 9'h008}, run);
      check("osc enable", nxt inside {9'h002, 9'h004, 9'h010, 9'h020}, osc);
      if (run === 1'b0) begin
        check("divide code", dsel, dsel_q);
        check("divisor", 4'h8 >> dsel, div);
        omtc_core_model_inst.request(0, 1'b0, 2'($urandom_range(2, 1)));
        repeat (3) @(negedge core_clk_i);
        check("masked mode", nxt, mode);
        check("masked pulse", 1'b0, hdl);
        omtc_core_model_inst.request($urandom_range(2), 1'($urandom), 2'h0);
        seen = 1'b0;
        n = 0;
        while (run !== 1'b1 && n < 1100) begin
          #1 seen |= hdl;
          @(negedge core_clk_i);
          n++;
        end
        check("mode after wake", exp_wake(nxt, sel), mode);
        check("wake pulse", 1'b1, seen);
        if (nxt == omtc_pkg::OMTC_STANDBY)
          check("settle wait", 1'b1, n >= (8 << settle));
        omtc_core_model_inst.quiet();
        nxt = exp_wake(nxt, sel);
      end
      cur = nxt;
    end
    // Pin reset after a sleep request with all select bits clear must reach the reset state, then active high speed.
    sel = 5'h00;
    omtc_core_model_inst.sleep_pulse();
    rst_n = 1'b0;
    repeat (4) @(negedge core_clk_i);
    check("pin reset mode", omtc_pkg::OMTC_RESET, mode);
    rst_n = 1'b1;
    n = 0;
    while (mode !== omtc_pkg::OMTC_ACT_HIGH && n < 8) begin
      @(negedge core_clk_i);
      n++;
    end
    check("mode after pin reset", omtc_pkg::OMTC_ACT_HIGH, mode);
    close_out();
  end
endmodule
